// ---- logic/svd_params.svh ----
`ifndef SVD_PARAMS_SVH
`define SVD_PARAMS_SVH

// Register byte offsets on the APB window
`define SVD_OFF_CONTROL 8'h00
`define SVD_OFF_CORE_IRQ 8'h04
`define SVD_OFF_FLAGS 8'h08
`define SVD_OFF_ENABLES 8'h0C
`define SVD_OFF_PRIORITIES 8'h10
`define SVD_OFF_FLAG_CLEAR 8'h14

// Control register field positions
`define SVD_CTL_DIR_BIT 7
`define SVD_CTL_STABLE_BIT 5
`define SVD_CTL_EN_BIT 4
`define SVD_CTL_LEVEL_MSB 3
`define SVD_CTL_LEVEL_LSB 0

// Interrupt bit positions
`define SVD_IRQ_BIT 2
`define SVD_GIE_BIT 7

// Reset values and codes
`define SVD_CTL_RESET 8'h05
`define SVD_LEVEL_RESET 4'h5
`define SVD_LEVEL_EXTERNAL 4'hF

// Reference settle interval, in ns, and clock rate
`define SVD_SETTLE_NS 20000
`define SVD_CLK_MHZ 100
`define SVD_SETTLE_CYCLES ((`SVD_SETTLE_NS * `SVD_CLK_MHZ + 999) / 1000)

`endif

// ---- logic/svd_pkg.sv ----
package svd_pkg;

   // Detector control states, one-hot
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_SETTLE = 3'b010,
      ST_ARMED = 3'b100
   } svd_state_t;

   // Trip level code
   typedef logic [3:0] svd_level_t;

endpackage

// ---- logic/svd_sync.sv ----
`timescale 1ns/1ps

module svd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   import svd_pkg::*;

   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] q_reg;
   logic [WIDTH-1:0] q_next;
   logic [WIDTH-1:0] agree;

   // A bit moves only once stages two and three agree, filtering one-cycle glitches
   assign agree = ~(s2_reg ^ s3_reg);
   assign q_next = (agree & s3_reg) | (~agree & q_reg);
   assign q = q_reg;

   // Stage one feeds stage two only
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

endmodule

// ---- logic/svd_settle_timer.sv ----
`timescale 1ns/1ps

module svd_settle_timer #(
   parameter int SETTLE_CYCLES = 2000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ref_on,
   output logic ref_stable
);
   import svd_pkg::*;

   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYCLES - 1);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic stable_reg;
   logic stable_next;
   wire logic at_last = (cnt_reg == LAST);

   // [R9] Fixed interval count
   assign cnt_next = (!ref_on) ? '0 : ((stable_reg || at_last) ? cnt_reg : cnt_reg + 1'b1);
   // [R10] Restart only from no user
   assign stable_next = ref_on & (stable_reg | at_last);
   assign ref_stable = stable_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         stable_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         stable_reg <= stable_next;
      end
   end

   // [R9] Stable after full count
   settle_count_a: assert property ( // [R9]
      @(posedge clk) disable iff (rst) $rose(ref_stable) |-> $past(cnt_reg) == LAST && $past(ref_on))
      else $error("reference stable before the settle count ended");

   // [R10] Loss of all users
   settle_drop_a: assert property ( // [R10]
      @(posedge clk) disable iff (rst) !ref_on |=> !ref_stable ##1 (!ref_stable || $past(ref_on)))
      else $error("reference stable kept with no user");

endmodule

// ---- logic/svd_detector.sv ----
`timescale 1ns/1ps
`include "svd_params.svh"

// Summary of operation
// [R1] While enabled, comparator result against internal reference drives event detection.
// [R2] Four-bit level field in control bits 3..0 picks one of sixteen trip points.
// [R3] Level code 1111 routes the external detect input to the comparator.
// [R4] Crossing the trip point in the chosen direction sets the event flag.
// [R5] Software disables, writes level, then direction before re-enabling.
// [R6] Software enables, then clears the event flag left from earlier events.
// [R7] Software sets interrupt enable and global enable bit 7 when wanted.
// [R8] No event flag or interrupt until the reference-stable bit is set.
// [R9] A fixed settle interval follows enabling; short excursions may be missed.
// [R10] Settle delay restarts only after all reference users were off.
// [R11] Detector works in sleep; a crossing sets the flag and wakes.
// [R12] After wake, vectoring happens only with global interrupts enabled.
// [R13] Reset returns all detector registers to reset values, detector off.
// [R14] Software should enable only briefly for checks, to save current.
// [R15] Direction clear detects falling to/below; set detects rising to/above.
// [R16] Reference-stable bit is read-only and shows readiness to flag events.
// [R17] Event flag stays set until software clears it.
module svd_detector #(
   parameter int SETTLE_CYCLES = `SVD_SETTLE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_above_async,
   input wire logic bor_ref_request_async,
   input wire logic sleep_mode,
   output svd_pkg::svd_level_t trip_level_sel,
   output logic external_input_sel,
   output logic comparator_enable,
   output logic reference_enable,
   output logic irq,
   output logic irq_high_priority,
   output logic wake_request,
   output logic vector_request
);
   import svd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic crossing_direction_select_reg;
   logic detector_power_enable_reg;
   svd_level_t trip_level_select_reg;
   logic global_irq_enable_reg;
   logic detector_event_flag_reg;
   logic detector_event_flag_next;
   logic detector_irq_enable_reg;
   logic detector_irq_priority_reg;
   svd_state_t state_reg;
   svd_state_t state_next;
   logic [31:0] prdata_reg;
   logic cmp_above;
   logic bor_ref_request;
   logic ref_ready;

   // Address match, shared by read and write decode
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
      addr_hit = (addr == offset);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   // Setup phase latches read data, access phase commits writes
   wire logic setup_ph = psel & ~penable;
   wire logic access_ph = psel & penable;
   wire logic wr_access = access_ph & pwrite;
   wire logic hit_ctl = addr_hit(paddr, `SVD_OFF_CONTROL);
   wire logic hit_core = addr_hit(paddr, `SVD_OFF_CORE_IRQ);
   wire logic hit_flags = addr_hit(paddr, `SVD_OFF_FLAGS);
   wire logic hit_enables = addr_hit(paddr, `SVD_OFF_ENABLES);
   wire logic hit_prio = addr_hit(paddr, `SVD_OFF_PRIORITIES);
   wire logic hit_clear = addr_hit(paddr, `SVD_OFF_FLAG_CLEAR);
   wire logic mapped = hit_ctl | hit_core | hit_flags | hit_enables | hit_prio | hit_clear;
   wire logic wr_ctl = wr_access & hit_ctl;
   wire logic wr_core = wr_access & hit_core;
   wire logic wr_enables = wr_access & hit_enables;
   wire logic wr_prio = wr_access & hit_prio;
   wire logic flag_clear = wr_access & hit_clear & pwdata[`SVD_IRQ_BIT];

   // Zero wait states; unmapped addresses answer with an error
   assign pready = access_ph;
   assign pslverr = access_ph & ~mapped;
   assign prdata = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Inputs from the analog side

   // Comparator and brown-out reference request are asynchronous to clk
   svd_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({bor_ref_request_async, cmp_above_async}),
      .q({bor_ref_request, cmp_above})
   );

   // [R10] Shared reference users
   wire logic ref_in_use = detector_power_enable_reg | bor_ref_request;

   svd_settle_timer #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .clk(clk),
      .rst(rst),
      .ref_on(ref_in_use),
      .ref_stable(ref_ready)
   );

   // [R16] Read-only readiness bit
   wire logic reference_stable_flag = detector_power_enable_reg & ref_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Analog control outputs

   // [R2] Trip point selection
   assign trip_level_sel = trip_level_select_reg;
   // [R3] External input routing
   assign external_input_sel = (trip_level_select_reg == `SVD_LEVEL_EXTERNAL);
   // [R1] Comparator powered while enabled
   assign comparator_enable = detector_power_enable_reg;
   assign reference_enable = detector_power_enable_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Detector state machine

   // [R15] Direction selects the crossing sense
   wire logic crossing = crossing_direction_select_reg ? cmp_above : ~cmp_above;

   // [R8] Arm only once stable
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (detector_power_enable_reg) begin
               state_next = ref_ready ? ST_ARMED : ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (!detector_power_enable_reg) begin
               state_next = ST_OFF;
            end else if (ref_ready) begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!detector_power_enable_reg) begin
               state_next = ST_OFF;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   // [R4] Flag set on crossing; set beats a same-cycle clear
   // Enable gate covers the cycle before the state falls back to off
   wire logic flag_set = (state_reg == ST_ARMED) & detector_power_enable_reg & crossing;
   // [R17] Sticky until cleared
   assign detector_event_flag_next = flag_set | (detector_event_flag_reg & ~flag_clear);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // [R13] Every register returns to reset value, detector off
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_OFF;
         detector_event_flag_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         detector_event_flag_reg <= detector_event_flag_next;
      end
   end

   // Control register; the stable bit is not writable
   always_ff @(posedge clk) begin
      if (rst) begin
         crossing_direction_select_reg <= 1'b0;
         detector_power_enable_reg <= 1'b0;
         trip_level_select_reg <= `SVD_LEVEL_RESET;
      end else if (wr_ctl) begin
         crossing_direction_select_reg <= pwdata[`SVD_CTL_DIR_BIT];
         detector_power_enable_reg <= pwdata[`SVD_CTL_EN_BIT];
         trip_level_select_reg <= pwdata[`SVD_CTL_LEVEL_MSB:`SVD_CTL_LEVEL_LSB];
      end
   end

   // Interrupt enable, priority and global enable
   always_ff @(posedge clk) begin
      if (rst) begin
         global_irq_enable_reg <= 1'b0;
         detector_irq_enable_reg <= 1'b0;
         detector_irq_priority_reg <= 1'b0;
      end else begin
         if (wr_core) global_irq_enable_reg <= pwdata[`SVD_GIE_BIT];
         if (wr_enables) detector_irq_enable_reg <= pwdata[`SVD_IRQ_BIT];
         if (wr_prio) detector_irq_priority_reg <= pwdata[`SVD_IRQ_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Unimplemented bits and the clear register read as zero
   wire logic [7:0] ctl_value = {crossing_direction_select_reg, 1'b0, reference_stable_flag,
                                 detector_power_enable_reg, trip_level_select_reg};
   wire logic [7:0] core_value = 8'(global_irq_enable_reg) << `SVD_GIE_BIT;
   wire logic [7:0] flags_value = 8'(detector_event_flag_reg) << `SVD_IRQ_BIT;
   wire logic [7:0] enables_value = 8'(detector_irq_enable_reg) << `SVD_IRQ_BIT;
   wire logic [7:0] prio_value = 8'(detector_irq_priority_reg) << `SVD_IRQ_BIT;
   wire logic [7:0] rd_value = hit_ctl ? ctl_value :
                               hit_core ? core_value :
                               hit_flags ? flags_value :
                               hit_enables ? enables_value :
                               hit_prio ? prio_value : 8'h00;

   // Read data captured in setup, held through access
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
      end else if (setup_ph && !pwrite) begin
         prdata_reg <= {24'h000000, rd_value};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt, wake and vector requests

   // Level interrupt while an enabled flag stands
   assign irq = detector_event_flag_reg & detector_irq_enable_reg;
   assign irq_high_priority = irq & detector_irq_priority_reg;
   // [R11] Wake from sleep on an enabled event
   assign wake_request = sleep_mode & irq;
   // [R12] Vector only with global enable, and once awake
   assign vector_request = irq & global_irq_enable_reg & ~sleep_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // [R4] Rising crossing sets flag
   flag_rise_a: assert property ( // [R4]
      @(posedge clk) disable iff (rst)
      (state_reg == ST_ARMED && detector_power_enable_reg && crossing_direction_select_reg && cmp_above)
      |=> detector_event_flag_reg)
      else $error("rising crossing did not set the event flag");

   // [R15] Falling crossing sets flag
   flag_fall_a: assert property ( // [R15]
      @(posedge clk) disable iff (rst)
      (state_reg == ST_ARMED && detector_power_enable_reg && !crossing_direction_select_reg && !cmp_above)
      |=> detector_event_flag_reg)
      else $error("falling crossing did not set the event flag");

   // [R8] Flag only after stable
   flag_gate_a: assert property ( // [R8]
      @(posedge clk) disable iff (rst)
      $rose(detector_event_flag_reg) |-> $past(reference_stable_flag) && $past(crossing))
      else $error("event flag set before the reference was stable");

   // [R17] Flag holds without clear
   flag_sticky_a: assert property ( // [R17]
      @(posedge clk) disable iff (rst)
      (detector_event_flag_reg && !flag_clear) |=> detector_event_flag_reg)
      else $error("event flag dropped without a clear");

   // [R3] External select follows level write
   ext_select_a: assert property ( // [R3]
      @(posedge clk) disable iff (rst)
      (wr_ctl && pwdata[3:0] == 4'hF) |=> external_input_sel ##1 (external_input_sel || $past(wr_ctl)))
      else $error("level 1111 did not select the external input");

   // [R2] Level field written
   level_write_a: assert property ( // [R2]
      @(posedge clk) disable iff (rst)
      wr_ctl |=> trip_level_sel == $past(pwdata[3:0]))
      else $error("trip level does not match the written field");

   // [R10] Shared reference skips settling
   shared_ref_a: assert property ( // [R10]
      @(posedge clk) disable iff (rst)
      ($rose(detector_power_enable_reg) && ref_ready && bor_ref_request) |=> state_reg == ST_ARMED)
      else $error("detector settled again while the reference stayed on");

   // [R11] Sleep wake on event
   sleep_wake_a: assert property ( // [R11]
      @(posedge clk) disable iff (rst)
      (flag_set && detector_irq_enable_reg && sleep_mode) |=> (wake_request || !sleep_mode))
      else $error("crossing in sleep did not request a wake");

   // [R12] Vector needs global enable
   vector_gate_a: assert property ( // [R12]
      @(posedge clk) disable iff (rst)
      vector_request |-> global_irq_enable_reg && detector_event_flag_reg && !sleep_mode)
      else $error("vector requested without global enable");

   // [R8] Armed means stable
   armed_stable_a: assert property ( // [R8]
      @(posedge clk) disable iff (rst)
      (state_reg == ST_ARMED && detector_power_enable_reg) |-> reference_stable_flag)
      else $error("armed without a stable reference");

   // [R9] Enable from cold settles
   settle_entry_a: assert property ( // [R9]
      @(posedge clk) disable iff (rst)
      ($rose(detector_power_enable_reg) && !ref_ready) |=> state_reg == ST_SETTLE)
      else $error("enable from a cold reference skipped settling");

   // [R9] No flag while settling
   settle_hold_a: assert property ( // [R9]
      @(posedge clk) disable iff (rst)
      (state_reg == ST_SETTLE && !detector_event_flag_reg) |=> !detector_event_flag_reg)
      else $error("event flag set while the reference settled");

   // [R1] Disable returns to off
   disable_off_a: assert property ( // [R1]
      @(posedge clk) disable iff (rst)
      !detector_power_enable_reg |=> state_reg == ST_OFF)
      else $error("detector stayed active after disable");

   // [R1] Disabled detector stays quiet
   disabled_quiet_a: assert property ( // [R1]
      @(posedge clk) disable iff (rst)
      (!detector_power_enable_reg && !detector_event_flag_reg) |=> !detector_event_flag_reg)
      else $error("event flag set while disabled");

   // [R17] Clear drops flag
   clear_drop_a: assert property ( // [R17]
      @(posedge clk) disable iff (rst)
      (flag_clear && !flag_set) |=> !detector_event_flag_reg)
      else $error("software clear did not drop the event flag");

   // [R13] Reset turns detector off
   reset_off_a: assert property ( // [R13]
      @(posedge clk) rst |=> !detector_power_enable_reg && !detector_event_flag_reg &&
                             trip_level_sel == `SVD_LEVEL_RESET && state_reg == ST_OFF)
      else $error("reset did not return the detector to its reset state");

endmodule

// ---- test/svd_detector_bench.sv ----
`timescale 1ns/1ps
`include "svd_params.svh"

module svd_detector_bench;
   import svd_pkg::*;

   logic clk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cmp_above_async;
   logic bor_ref_request_async;
   logic sleep_mode;
   svd_level_t trip_level_sel;
   logic external_input_sel;
   logic comparator_enable;
   logic reference_enable;
   logic irq;
   logic irq_high_priority;
   logic wake_request;
   logic vector_request;
   int failures;
   int num_checks;
   int i;

   // Short settle count keeps the run brief
   svd_detector #(.SETTLE_CYCLES(8)) uut (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_above_async(cmp_above_async), .bor_ref_request_async(bor_ref_request_async),
      .sleep_mode(sleep_mode), .trip_level_sel(trip_level_sel),
      .external_input_sel(external_input_sel), .comparator_enable(comparator_enable),
      .reference_enable(reference_enable), .irq(irq), .irq_high_priority(irq_high_priority),
      .wake_request(wake_request), .vector_request(vector_request)
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task results;
      begin
         if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         num_checks++;
         if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            failures++;
         end
      end
   endtask

   // One APB transfer; ends with an idle edge so back-to-back calls never double-drive
   task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
            output logic err);
      int n;
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= {24'h000000, d};
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (pready !== 1'b1 && n < 50);
         if (pready !== 1'b1) begin
            $display("Error at %0t: no ready", $time);
            failures++;
            results();
         end
         q = prdata[7:0];
         err = pslverr;
         chk({7'h00, |prdata[31:8]}, 8'h00);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      begin
         apb(1'b1, a, d, q, e);
         chk({7'h00, e}, 8'h00);
      end
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      logic e;
      begin
         apb(1'b0, a, 8'h00, q, e);
         chk(q, exp);
         chk({7'h00, e}, 8'h00);
      end
   endtask

   // Bounded wait for the interrupt line
   task wait_irq(input logic exp);
      int n;
      begin
         n = 0;
         while (irq !== exp && n < 40) begin
            @(posedge clk);
            n++;
         end
         chk({7'h00, irq}, {7'h00, exp});
         if (irq !== exp) begin
            results();
         end
      end
   endtask

   task idle(input int n);
      begin
         repeat (n) @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0] q;
      logic e;
      failures = 0;
      num_checks = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      cmp_above_async = 1'b1;
      bor_ref_request_async = 1'b0;
      sleep_mode = 1'b0;
      idle(10);
      rst <= 1'b0;
      @(posedge clk);
      // Reset state of registers and outputs
      rd(`SVD_OFF_CONTROL, 8'h05);
      rd(`SVD_OFF_FLAGS, 8'h00);
      rd(`SVD_OFF_ENABLES, 8'h00);
      chk({7'h00, reference_enable}, 8'h00);
      // Unmapped place answers with an error and zero data
      apb(1'b0, 8'h18, 8'h00, q, e);
      chk({7'h00, e}, 8'h01);
      chk(q, 8'h00);
      apb(1'b1, 8'h1C, 8'hFF, q, e);
      chk({7'h00, e}, 8'h01);
      // Every level code, the top one picks the external input
      for (i = 0; i < 16; i++) begin
         wr(`SVD_OFF_CONTROL, i[7:0]);
         rd(`SVD_OFF_CONTROL, i[7:0]);
         chk({4'h0, trip_level_sel}, i[7:0]);
         chk({7'h00, external_input_sel}, {7'h00, i == 15});
      end
      // Stable bit cannot be written
      wr(`SVD_OFF_CONTROL, 8'h23);
      rd(`SVD_OFF_CONTROL, 8'h03);
      wr(`SVD_OFF_CORE_IRQ, 8'hFF);
      rd(`SVD_OFF_CORE_IRQ, 8'h80);
      wr(`SVD_OFF_CORE_IRQ, 8'h00);
      wr(`SVD_OFF_ENABLES, 8'h04);
      rd(`SVD_OFF_ENABLES, 8'h04);
      // Falling detection; a short dip while settling is lost
      wr(`SVD_OFF_CONTROL, 8'h13);
      cmp_above_async <= 1'b0;
      @(posedge clk);
      cmp_above_async <= 1'b1;
      rd(`SVD_OFF_CONTROL, 8'h13);
      chk({6'h00, reference_enable, comparator_enable}, 8'h03);
      idle(12);
      rd(`SVD_OFF_CONTROL, 8'h33);
      rd(`SVD_OFF_FLAGS, 8'h00);
      cmp_above_async <= 1'b0;
      wait_irq(1'b1);
      rd(`SVD_OFF_FLAGS, 8'h04);
      cmp_above_async <= 1'b1;
      idle(8);
      rd(`SVD_OFF_FLAGS, 8'h04);
      wr(`SVD_OFF_FLAGS, 8'h00);
      rd(`SVD_OFF_FLAGS, 8'h04);
      // Priority routing
      chk({7'h00, irq_high_priority}, 8'h00);
      wr(`SVD_OFF_PRIORITIES, 8'h04);
      rd(`SVD_OFF_PRIORITIES, 8'h04);
      chk({7'h00, irq_high_priority}, 8'h01);
      // Sleep wake, vector only with global enable
      sleep_mode <= 1'b1;
      idle(2);
      chk({6'h00, wake_request, vector_request}, 8'h02);
      sleep_mode <= 1'b0;
      idle(2);
      chk({6'h00, wake_request, vector_request}, 8'h00);
      wr(`SVD_OFF_CORE_IRQ, 8'h80);
      chk({7'h00, vector_request}, 8'h01);
      wr(`SVD_OFF_CORE_IRQ, 8'h00);
      // Software clear
      wr(`SVD_OFF_FLAG_CLEAR, 8'h04);
      rd(`SVD_OFF_FLAGS, 8'h00);
      chk({7'h00, irq}, 8'h00);
      // Rising detection
      cmp_above_async <= 1'b0;
      wr(`SVD_OFF_CONTROL, 8'h03);
      rd(`SVD_OFF_CONTROL, 8'h03);
      wr(`SVD_OFF_CONTROL, 8'h83);
      wr(`SVD_OFF_CONTROL, 8'h93);
      idle(12);
      rd(`SVD_OFF_CONTROL, 8'hB3);
      rd(`SVD_OFF_FLAGS, 8'h00);
      cmp_above_async <= 1'b1;
      wait_irq(1'b1);
      cmp_above_async <= 1'b0;
      idle(6);
      wr(`SVD_OFF_FLAG_CLEAR, 8'h04);
      wait_irq(1'b0);
      // Brown-out request reaches the reference two cycles after the disable, so the shared reference settles again
      bor_ref_request_async <= 1'b1;
      wr(`SVD_OFF_CONTROL, 8'h83);
      idle(14);
      wr(`SVD_OFF_CONTROL, 8'h93);
      rd(`SVD_OFF_CONTROL, 8'hB3);
      // Reset in mid-run with a pending event
      cmp_above_async <= 1'b1;
      wait_irq(1'b1);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      @(posedge clk);
      rd(`SVD_OFF_CONTROL, 8'h05);
      rd(`SVD_OFF_FLAGS, 8'h00);
      rd(`SVD_OFF_PRIORITIES, 8'h00);
      chk({6'h00, irq, reference_enable}, 8'h00);
      results();
   end

   // Overall guard against a hang
   initial begin
      repeat (20000) @(posedge clk);
      $display("Error at %0t: run too long", $time);
      failures++;
      results();
   end

endmodule
